// ===== hdl/usbsc_line_timer.sv
`timescale 1ns/10ps
// registers the line state and counts how long it has stayed unchanged
module usbsc_line_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // line
    input wire logic line_dp,
    input wire logic line_dm,
    // state and stable time
    output logic [1:0] line_state,
    output logic [usbsc_pkg::CNT_W-1:0] stable_cnt
);
    import usbsc_pkg::*;
    logic [1:0] now;
    logic sat;
    assign now = {line_dp, line_dm};
    assign sat = &stable_cnt;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_state <= LINE_SE0;
            stable_cnt <= '0;
        end else begin
            line_state <= now;
            if (now != line_state) begin
                stable_cnt <= '0;
            end else if (!sat) begin
                stable_cnt <= stable_cnt + 1'b1;
            end
        end
    end
endmodule

// ===== hdl/usbsc_top.sv
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module usbsc_top #(
    parameter logic [usbsc_pkg::CNT_W-1:0] DEV_CHIRP_CYC = usbsc_pkg::CNT_W'(usbsc_pkg::cyc_min(1_000_000)),
    parameter logic [usbsc_pkg::CNT_W-1:0] HS_WAIT_CYC = usbsc_pkg::CNT_W'(usbsc_pkg::cyc_min(2_000_000)),
    parameter logic [usbsc_pkg::CNT_W-1:0] HOST_RESET_CYC = usbsc_pkg::CNT_W'(usbsc_pkg::cyc_min(10_000_000))
) (
    // clock and reset (reset is the chip reset pin)
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [usbsc_pkg::AXI_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [usbsc_pkg::AXI_DW-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [usbsc_pkg::AXI_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [usbsc_pkg::AXI_DW-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // usb line
    input wire logic line_dp,
    input wire logic line_dm,
    output logic dplus_pullup_enable,
    output logic line_pulldown_enable,
    output logic drive_se0,
    output logic drive_chirp_k,
    output logic [2:0] link_speed,
    // interrupt
    output logic irq
);
    import usbsc_pkg::*;

    function automatic logic is_tbl(input logic [AXI_AW-1:0] a);
        return (a >= OFS_TBL) && (a < AXI_AW'(OFS_TBL + 4 * TBL_N)) && (a[1:0] == 2'h0);
    endfunction
    function automatic logic [3:0] tbl_idx(input logic [AXI_AW-1:0] a);
        logic [AXI_AW-1:0] d;
        d = a - OFS_TBL;
        return d[5:2];
    endfunction
    function automatic logic mapped(input logic [AXI_AW-1:0] a);
        return (a == OFS_SYS_CFG) || (a == OFS_DEV_STATE) || (a == OFS_INTSTS) || (a == OFS_INTMSK) || is_tbl(a);
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[8*i +: 8] = n[8*i +: 8];
        end
        return r;
    endfunction

    // ---------------- registers ----------------
    logic [15:0] cfg_q;
    logic [INT_W-1:0] msk_q, sts_q, sts_d, ev;
    logic [2:0] rh_q, rh_d;
    logic busrst_req_q, attached_q, attach_ls_q, hs_seen_q;
    logic [31:0] tbl_q [TBL_N];
    usbsc_state_t st_q, st_d;
    logic [CNT_W-1:0] tmr_q, tmr_d;
    logic [1:0] ls;
    logic [CNT_W-1:0] ls_cnt;

    usbsc_line_timer u_line (
        .aclk(aclk),
        .aresetn(aresetn),
        .line_dp(line_dp),
        .line_dm(line_dm),
        .line_state(ls),
        .stable_cnt(ls_cnt)
    );

    // ---------------- axi write path ----------------
    logic aw_full_q, w_full_q;
    logic [AXI_AW-1:0] wa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    wire wr_fire = aw_full_q && w_full_q && !bvalid;
    wire wr_ok = wr_fire && mapped(wa_q);
    wire [31:0] wr_cfg = merge({16'h0000, cfg_q}, wd_q, ws_q);
    wire [31:0] wr_dvst = merge(32'h0000_0000, wd_q, ws_q);
    wire [31:0] wr_msk = merge({29'h0, msk_q}, wd_q, ws_q);
    wire [3:0] wr_idx = tbl_idx(wa_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            wa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                awready <= 1'b0;
                wa_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                wready <= 1'b0;
                wd_q <= wdata;
                ws_q <= wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= mapped(wa_q) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ---------------- axi read path ----------------
    wire rd_fire = arvalid && arready;
    wire [3:0] rd_idx = tbl_idx(araddr);
    wire [31:0] rd_word =
        (araddr == OFS_SYS_CFG) ? {16'h0000, cfg_q} :
        (araddr == OFS_DEV_STATE) ? {25'h0, busrst_req_q, 3'h0, rh_q} :
        (araddr == OFS_INTSTS) ? {29'h0, sts_q} :
        (araddr == OFS_INTMSK) ? {29'h0, msk_q} :
        is_tbl(araddr) ? tbl_q[rd_idx] : 32'h0000_0000;
    wire sts_clr = rd_fire && (araddr == OFS_INTSTS);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= RESP_OKAY;
        end else begin
            if (rd_fire) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_word;
                rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ---------------- software registers ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= '0;
            msk_q <= '0;
            for (int i = 0; i < TBL_N; i++) tbl_q[i] <= '0;
        end else if (wr_ok) begin
            if (wa_q == OFS_SYS_CFG) cfg_q <= wr_cfg[15:0] & CFG_MASK;
            if (wa_q == OFS_INTMSK) msk_q <= wr_msk[INT_W-1:0];
            if (is_tbl(wa_q)) begin
                tbl_q[wr_idx] <= merge(tbl_q[wr_idx], wd_q, ws_q) & ((wr_idx == IDX_D1_DATA) ? MASK_WIDE : MASK_HALF);
            end
        end
    end

    // ---------------- role, speed and reset handshake ----------------
    wire fn = !cfg_q[BIT_ROLE];
    wire hs_en = cfg_q[BIT_HS_EN];
    wire se0_hit = (ls == LINE_SE0) && (ls_cnt == RESET_DET_CYC);
    wire k_hit = (ls == LINE_K) && (ls_cnt == CHIRP_DET_CYC);
    wire att_hit = (ls == LINE_J || ls == LINE_K) && (ls_cnt == RESET_DET_CYC);
    wire sw_busrst = wr_ok && (wa_q == OFS_DEV_STATE) && wr_dvst[BIT_BUSRST];
    wire [2:0] host_rh = (hs_seen_q && hs_en) ? RH_HS : (attach_ls_q ? RH_LS : RH_FS);

    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + 1'b1;
        rh_d = rh_q;
        ev = '0;
        unique case (st_q)
            ST_IDLE: begin
                tmr_d = '0;
                if (fn && se0_hit) begin
                    st_d = ST_RST;
                    ev[IRQ_BUSRST] = 1'b1;
                end else if (!fn && busrst_req_q) begin
                    st_d = ST_RST;
                end
                if (!fn && !attached_q && att_hit) ev[IRQ_ATTACH] = 1'b1;
            end
            ST_RST: begin
                rh_d = RH_BUSY;
                if (fn) begin
                    tmr_d = '0;
                    if (hs_en) begin
                        st_d = ST_CHIRP;
                    end else begin
                        st_d = ST_DONE;
                        rh_d = RH_FS;
                    end
                end else if (tmr_q == HOST_RESET_CYC) begin
                    st_d = ST_DONE;
                    rh_d = host_rh;
                end
            end
            ST_CHIRP: begin
                if (tmr_q == DEV_CHIRP_CYC) begin
                    st_d = ST_LISTEN;
                    tmr_d = '0;
                end
            end
            ST_LISTEN: begin
                if (k_hit) begin
                    st_d = ST_DONE;
                    rh_d = RH_HS;
                end else if (tmr_q == HS_WAIT_CYC) begin
                    st_d = ST_DONE;
                    rh_d = RH_FS;
                end
            end
            ST_DONE: begin
                tmr_d = '0;
                if (!fn || ls != LINE_SE0) st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
                tmr_d = '0;
            end
        endcase
        if (st_q != ST_DONE && st_d == ST_DONE) ev[IRQ_HSDONE] = 1'b1;
    end

    // set wins over the read-clear
    assign sts_d = (sts_q & ~(sts_clr ? {INT_W{1'b1}} : {INT_W{1'b0}})) | ev;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
            tmr_q <= '0;
            rh_q <= RH_NONE;
            sts_q <= '0;
            busrst_req_q <= 1'b0;
            attached_q <= 1'b0;
            attach_ls_q <= 1'b0;
            hs_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            rh_q <= rh_d;
            sts_q <= sts_d;
            if (st_d == ST_DONE) busrst_req_q <= 1'b0;
            else if (sw_busrst) busrst_req_q <= 1'b1;
            if (ev[IRQ_ATTACH]) begin
                attached_q <= 1'b1;
                attach_ls_q <= (ls == LINE_K);
            end else if (fn || (st_q == ST_IDLE && se0_hit)) begin
                attached_q <= 1'b0;
            end
            if (st_q != ST_RST) hs_seen_q <= 1'b0;
            else if (k_hit) hs_seen_q <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dplus_pullup_enable <= 1'b0;
            line_pulldown_enable <= 1'b0;
            drive_se0 <= 1'b0;
            drive_chirp_k <= 1'b0;
            link_speed <= RH_NONE;
            irq <= 1'b0;
        end else begin
            dplus_pullup_enable <= fn && cfg_q[BIT_PU];
            line_pulldown_enable <= !fn && cfg_q[BIT_PD];
            drive_se0 <= !fn && (st_d == ST_RST);
            drive_chirp_k <= fn && (st_d == ST_CHIRP);
            link_speed <= rh_d;
            irq <= |(sts_d & msk_q);
        end
    end

    // ---------------- assertions ----------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_init;
        $rose(aresetn) |-> (cfg_q == 16'h0000) && (rh_q == RH_NONE) && (st_q == ST_IDLE) && !irq;
    endproperty
    a_reset_init: assert property (p_reset_init) else $error("state not initialised by reset");

    property p_fn_busrst;
        (st_q == ST_IDLE) && fn && se0_hit |=> (st_q == ST_RST) && sts_q[IRQ_BUSRST];
    endproperty
    a_fn_busrst: assert property (p_fn_busrst) else $error("function bus reset not detected");

    property p_role_pins;
        ##1 (dplus_pullup_enable == ($past(fn) && $past(cfg_q[BIT_PU])))
            && (line_pulldown_enable == (!$past(fn) && $past(cfg_q[BIT_PD])));
    endproperty
    a_role_pins: assert property (p_role_pins) else $error("pull resistors not set by role");

    property p_fn_no_ls;
        fn && (st_d == ST_DONE) && (st_q != ST_DONE) |=> (rh_q == RH_HS) || (rh_q == RH_FS);
    endproperty
    a_fn_no_ls: assert property (p_fn_no_ls) else $error("function reached low speed");

    property p_hs_chirp;
        (st_q == ST_RST) && fn && hs_en |=> (st_q == ST_CHIRP) ##0 drive_chirp_k [*2];
    endproperty
    a_hs_chirp: assert property (p_hs_chirp) else $error("no chirp with high speed enabled");

    property p_result_shown;
        (st_q == ST_DONE) |-> (link_speed == rh_q) && (rh_q != RH_BUSY) && (rh_q != RH_NONE);
    endproperty
    a_result_shown: assert property (p_result_shown) else $error("handshake result not reported");

    property p_fn_fs;
        (st_q == ST_RST) && fn && !hs_en |=> (st_q == ST_DONE) && (rh_q == RH_FS);
    endproperty
    a_fn_fs: assert property (p_fn_fs) else $error("function without high speed not full speed");

    property p_no_chirp;
        fn && !hs_en && !drive_chirp_k |=> !drive_chirp_k;
    endproperty
    a_no_chirp: assert property (p_no_chirp) else $error("chirp driven with high speed off");

    c_fn_hs: cover property ((st_q == ST_LISTEN) ##1 (st_q == ST_DONE) && (rh_q == RH_HS));
    c_host_reset: cover property (drive_se0 ##1 !drive_se0 && (rh_q != RH_BUSY));
    c_attach_irq: cover property (sts_q[IRQ_ATTACH] && irq);
endmodule

// ===== pkg/usbsc_pkg.sv
package usbsc_pkg;
    localparam int CLK_NS = 40;
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam int CNT_W = 18;
    localparam int INT_W = 3;
    localparam int TBL_N = 13;

    // line timing, in ns
    localparam int RESET_DET_NS = 2500;
    localparam int CHIRP_DET_NS = 2500;
    localparam int DEV_CHIRP_NS = 1_000_000;
    localparam int HS_WAIT_NS = 2_000_000;
    localparam int HOST_RESET_NS = 10_000_000;

    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [CNT_W-1:0] RESET_DET_CYC = CNT_W'(cyc_min(RESET_DET_NS));
    localparam logic [CNT_W-1:0] CHIRP_DET_CYC = CNT_W'(cyc_min(CHIRP_DET_NS));

    // register map (byte addresses)
    localparam logic [AXI_AW-1:0] OFS_SYS_CFG = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_DEV_STATE = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_INTSTS = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_INTMSK = 8'h0C;
    localparam logic [AXI_AW-1:0] OFS_TBL = 8'h40;
    // table indices, tbl word i sits at OFS_TBL + 4*i
    localparam logic [3:0] IDX_D1_DATA = 4'h0;
    localparam logic [3:0] IDX_CPU_SEL = 4'h1;
    localparam logic [3:0] IDX_CPU_CTRL = 4'h2;
    localparam logic [3:0] IDX_DMA0_SEL = 4'h3;
    localparam logic [3:0] IDX_DMA0_CTRL = 4'h4;
    localparam logic [3:0] IDX_DMA1_SEL = 4'h5;
    localparam logic [3:0] IDX_DMA1_CTRL = 4'h6;
    localparam logic [3:0] IDX_IEN_MAIN = 4'h7;
    localparam logic [3:0] IDX_IEN_HOST = 4'h8;
    localparam logic [3:0] IDX_READY_EN = 4'h9;
    localparam logic [3:0] IDX_NOTREADY_EN = 4'hA;
    localparam logic [3:0] IDX_EMPTY_EN = 4'hB;
    localparam logic [3:0] IDX_FRAME_CFG = 4'hC;
    localparam logic [31:0] MASK_WIDE = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_HALF = 32'h0000_FFFF;

    // system config fields
    localparam int BIT_PU = 4;
    localparam int BIT_PD = 5;
    localparam int BIT_ROLE = 6;
    localparam int BIT_HS_EN = 7;
    localparam logic [15:0] CFG_MASK = 16'h00F0;
    // device state control fields
    localparam int BIT_BUSRST = 6;
    // interrupt status bits
    localparam int IRQ_ATTACH = 0;
    localparam int IRQ_BUSRST = 1;
    localparam int IRQ_HSDONE = 2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // line state {dp, dm}
    localparam logic [1:0] LINE_SE0 = 2'h0;
    localparam logic [1:0] LINE_K = 2'h1;
    localparam logic [1:0] LINE_J = 2'h2;

    // reset handshake result
    localparam logic [2:0] RH_NONE = 3'h0;
    localparam logic [2:0] RH_LS = 3'h1;
    localparam logic [2:0] RH_FS = 3'h2;
    localparam logic [2:0] RH_HS = 3'h3;
    localparam logic [2:0] RH_BUSY = 3'h4;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_RST = 3'h1,
        ST_CHIRP = 3'h3,
        ST_LISTEN = 3'h2,
        ST_DONE = 3'h6
    } usbsc_state_t;
endpackage

// ===== tb/tb_usbsc_top.sv
`timescale 1ns/10ps
module tb_usbsc_top;
    import usbsc_pkg::*;
    typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; bit rd;} usbsc_exp_t;
    localparam int DEV_CHIRP = 40;
    localparam int HOST_RST = 100;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, peer_mode = 2'd0;
    logic [31:0] rdata, d;
    logic line_dp, line_dm, pu, pd, drive_se0, drive_chirp_k, peer_hs = 1'b0;
    logic [2:0] link_speed;
    int bad_count = 0, checks = 0, se0_len = 0, chirp_len = 0;
    usbsc_exp_t exp_q[$];
    usbsc_exp_t e;
    logic [1:0] h_att [4] = '{2'd1, 2'd2, 2'd1, 2'd1};
    logic h_hsen [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic h_hs [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic [2:0] h_exp [4] = '{RH_FS, RH_LS, RH_FS, RH_HS};
    logic f_hsen [3] = '{1'b1, 1'b1, 1'b0};
    logic f_hs [3] = '{1'b0, 1'b1, 1'b1};
    logic [2:0] f_exp [3] = '{RH_FS, RH_HS, RH_FS};

    always #20 aclk = ~aclk;

    usbsc_top #(.DEV_CHIRP_CYC(18'd40), .HS_WAIT_CYC(18'd200), .HOST_RESET_CYC(18'd100)) i_usbsc_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .line_dp(line_dp), .line_dm(line_dm),
        .dplus_pullup_enable(pu), .line_pulldown_enable(pd), .drive_se0(drive_se0),
        .drive_chirp_k(drive_chirp_k), .link_speed(link_speed), .irq(irq));

    usbsc_peer i_usbsc_peer (
        .aclk(aclk), .mode(peer_mode), .hs_capable(peer_hs), .drive_se0(drive_se0),
        .drive_chirp_k(drive_chirp_k), .dplus_pullup_enable(pu), .line_pulldown_enable(pd),
        .line_dp(line_dp), .line_dm(line_dm));

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // monitor: every bus answer is matched against the oldest expectation
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("[FAIL] bus answer with nothing expected");
            end else begin
                e = exp_q.pop_front();
                if (e.rd) begin
                    check("rdata", rdata & e.m, e.d);
                    check("rresp", rresp, e.r);
                end else
                    check("bresp", bresp, e.r);
            end
        end
        if (drive_se0)
            se0_len++;
        if (drive_chirp_k)
            chirp_len++;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = RESP_OKAY,
                      input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        exp_q.push_back('{d: 32'h0000_0000, m: 32'h0000_0000, r: r, rd: 1'b0});
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            n++;
        end while (!(bvalid && bready) && n < 200);
        bready <= 1'b0;
        if (n >= 200)
            bad_count++;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m, input logic [1:0] r = RESP_OKAY);
        int n;
        n = 0;
        exp_q.push_back('{d: v, m: m, r: r, rd: 1'b1});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            n++;
        end while (!(rvalid && rready) && n < 200);
        rready <= 1'b0;
        if (n >= 200)
            bad_count++;
    endtask

    // bounded wait: 0 irq, otherwise link_speed
    task automatic wait_for(input int w, input logic [2:0] v);
        int n;
        logic [2:0] s;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            s = (w == 0) ? {2'b00, irq} : link_speed;
        end while (s !== v && n < 2000);
        if (n >= 2000) begin
            bad_count++;
            $display("[FAIL] wait %0d for %h timed out", w, v);
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        final_report();
    end

    initial begin
        void'($urandom(61));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("line outputs", {pu, pd, drive_se0, drive_chirp_k, link_speed, irq}, 0);
        for (int i = 0; i < 4; i++)
            rd(8'(4 * i), 0, 32'hFFFF_FFFF);
        for (int i = 0; i < TBL_N; i++) begin
            d = $urandom;
            wr(OFS_TBL + 8'(4 * i), d);
            rd(OFS_TBL + 8'(4 * i), (i == 0) ? d : d & MASK_HALF, 32'hFFFF_FFFF);
        end
        wr(8'h30, 32'h0000_0001, RESP_SLVERR);
        rd(8'h30, 0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(OFS_INTSTS, 32'h0000_00FF);
        rd(OFS_INTSTS, 0, 32'hFFFF_FFFF);
        wr(OFS_INTMSK, 32'h0000_0001);
        wr(OFS_SYS_CFG, 32'h0000_0060);
        @(posedge aclk);
        check("host pull", {pu, pd}, 2'b01);
        for (int i = 0; i < 4; i++) begin
            peer_hs <= h_hs[i];
            peer_mode <= h_att[i];
            wait_for(0, 3'd1);
            rd(OFS_INTSTS, 32'h0000_0001, 32'h0000_0001);
            wr(OFS_SYS_CFG, 32'h0000_0060 | (32'(h_hsen[i]) << BIT_HS_EN));
            wr(OFS_INTMSK, 0);
            se0_len = 0;
            wr(OFS_DEV_STATE, 32'h0000_0040);
            wait_for(2, h_exp[i]);
            repeat (2) @(posedge aclk);
            check("host speed", link_speed, h_exp[i]);
            check("bus reset length", se0_len, HOST_RST + 1);
            check("irq masked", irq, 0);
            wr(OFS_INTMSK, 32'h0000_0007);
            repeat (2) @(posedge aclk);
            check("irq unmasked", irq, 1);
            rd(OFS_INTSTS, 32'h0000_0004, 32'h0000_0004);
            repeat (2) @(posedge aclk);
            check("irq cleared", irq, 0);
            rd(OFS_DEV_STATE, 32'(h_exp[i]), 32'h0000_0047);
            wr(OFS_INTMSK, 32'h0000_0001);
            peer_mode <= 2'd0;
            repeat (80) @(posedge aclk);
        end
        wr(OFS_SYS_CFG, 32'h0000_0040);
        wr(OFS_SYS_CFG, 0);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_SYS_CFG, 32'(f_hsen[i]) << BIT_HS_EN);
            wr(OFS_SYS_CFG, 32'h0000_0010 | (32'(f_hsen[i]) << BIT_HS_EN));
            @(posedge aclk);
            check("function pull", {pu, pd}, 2'b10);
            wr(OFS_INTMSK, 32'h0000_0002);
            chirp_len = 0;
            peer_hs <= f_hs[i];
            peer_mode <= 2'd3;
            wait_for(0, 3'd1);
            wait_for(2, f_exp[i]);
            check("function speed", link_speed, f_exp[i]);
            check("chirp length", chirp_len, f_hsen[i] ? DEV_CHIRP + 1 : 0);
            rd(OFS_INTSTS, 32'h0000_0002, 32'h0000_0002);
            rd(OFS_DEV_STATE, 32'(f_exp[i]), 32'h0000_0007);
            peer_mode <= 2'd0;
            wr(OFS_SYS_CFG, 0);
        end
        wr(OFS_SYS_CFG, 32'h0000_0090);
        wr(OFS_TBL + 8'h04, 32'h0000_1234);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        check("speed after reset", link_speed, 0);
        rd(OFS_SYS_CFG, 0, 32'hFFFF_FFFF);
        rd(OFS_TBL + 8'h04, 0, 32'hFFFF_FFFF);
        // byte strobes: lanes 0 and 2 take the new data, lanes 1 and 3 keep the old
        wr(OFS_TBL, 32'h1234_5678);
        wr(OFS_TBL, 32'hABCD_EF01, RESP_OKAY, 4'h5);
        rd(OFS_TBL, 32'h12CD_5601, 32'hFFFF_FFFF);
        repeat (2) @(posedge aclk);
        final_report();
    end
endmodule

// ===== tb/usbsc_peer.sv
`timescale 1ns/10ps
// far end of the usb line: a device while the block is host, a host while the block is a function
module usbsc_peer (
    // clock
    input wire logic aclk,
    // bench control: 0 released, 1 attach j, 2 attach k, 3 send bus reset
    input wire logic [1:0] mode,
    input wire logic hs_capable,
    // block side of the line
    input wire logic drive_se0,
    input wire logic drive_chirp_k,
    input wire logic dplus_pullup_enable,
    input wire logic line_pulldown_enable,
    // line
    output logic line_dp,
    output logic line_dm
);
    import usbsc_pkg::*;
    int cnt = 0;
    int kcnt = 0;
    logic chirped = 1'b0;
    logic tog = 1'b0;
    logic [1:0] line;

    always @(posedge aclk) begin
        tog <= ~tog;
        if (mode == 2'd3 || drive_se0) begin
            cnt <= cnt + 1;
            if (drive_chirp_k)
                chirped <= 1'b1;
            else if (chirped && hs_capable && kcnt < 80)
                kcnt <= kcnt + 1;
        end else begin
            cnt <= 0;
            kcnt <= 0;
            chirped <= 1'b0;
        end
    end

    // an undriven line with no pull never looks stable: it alternates every cycle
    always_comb begin
        if (mode == 2'd3) begin
            if (drive_chirp_k)
                line = LINE_K;
            else if (chirped && hs_capable)
                line = (kcnt < 80) ? LINE_K : LINE_J;
            else
                line = (cnt < 300) ? LINE_SE0 : LINE_J;
        end else if (drive_se0)
            line = (hs_capable && cnt >= 5 && cnt < 85) ? LINE_K : LINE_SE0;
        else if (mode == 2'd1)
            line = LINE_J;
        else if (mode == 2'd2)
            line = LINE_K;
        else if (line_pulldown_enable)
            line = LINE_SE0;
        else if (dplus_pullup_enable)
            line = LINE_J;
        else
            line = tog ? LINE_J : LINE_K;
    end
    assign line_dp = line[1];
    assign line_dm = line[0];
endmodule
